// ===== design/month_year_minute_alarm_regs.sv
// month with century flag, year, and minute alarm register set
`timescale 1ns/1ps
`default_nettype none
module month_year_minute_alarm_regs
    import cal_regs_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // register port from the serial interface
    input  wire logic [7:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    // calendar events from the date counter
    input  wire logic       month_tick_i,
    output logic      [5:0] days_in_month_o,
    output logic            leap_year_o,
    // minute compare
    input  wire logic [6:0] minutes_i,
    output logic            minute_match_o
);
    cal_info_if cal ();

    // architectural state
    logic [4:0] month;
    logic [7:0] year_count;
    logic       century_flag;
    logic       minute_match_disable;
    logic [6:0] minute_match_value;

    // strobes, carries and next values
    logic       wr_month;
    logic       wr_year;
    logic       wr_alarm;
    logic       year_step;
    logic       year_wrap;
    logic [4:0] next_month;
    logic [7:0] next_year;
    logic       next_century;
    logic [7:0] next_rdata;
    // write data fields and minute compare
    logic       minute_equal;
    logic [4:0] wdata_month;
    logic       wdata_century;
    logic       wdata_disable;
    logic [6:0] wdata_match;

    // two digit bcd increment; the caller handles the wrap
    // an illegal units digit above 9 also carries, so no stuck value
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        logic [7:0] r;
        r = v;
        if (v[3:0] >= 4'h9) begin
            r[3:0] = 4'h0;
            r[7:4] = v[7:4] + 4'h1;
        end else begin
            r[3:0] = v[3:0] + 4'h1;
        end
        return r;
    endfunction : bcd_inc

    // write data split into fields, bits 6:5 of the month byte dropped
    assign wdata_month   = reg_wdata_i[MONTH_MSB:0];
    assign wdata_century = reg_wdata_i[CENTURY_BIT];
    assign wdata_disable = reg_wdata_i[MATCH_DISABLE_BIT];
    assign wdata_match   = reg_wdata_i[MATCH_VALUE_MSB:0];

    // write strobes per register
    // the full byte offset is decoded, so no aliases of the registers
    assign wr_month = reg_wr_i && (reg_addr_i == OFS_MONTH_AND_CENTURY);
    assign wr_year  = reg_wr_i && (reg_addr_i == OFS_YEAR_COUNT);
    assign wr_alarm = reg_wr_i && (reg_addr_i == OFS_MINUTE_MATCH_VALUE);

    // december end carries into the year
    assign year_step = month_tick_i && (month == MONTH_LAST);
    // a year write in the same cycle cancels the carry
    assign year_wrap = year_step && !wr_year && (year_count == YEAR_LAST);

    always_comb begin
        if (month == MONTH_LAST) begin
            next_month = MONTH_FIRST;
        end else begin
            next_month = 5'(bcd_inc({3'b000, month}));
        end
    end

    // year advance
    // 99 back to 00; the century flag follows from year_wrap
    always_comb begin
        if (year_count == YEAR_LAST) begin
            next_year = 8'h00;
        end else begin
            next_year = bcd_inc(year_count);
        end
    end

    // month register, software write wins over the tick
    // stored unchecked; an illegal code then steps by the bcd increment
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            month <= RST_MONTH;
        end else if (wr_month) begin
            month <= wdata_month;
        end else if (month_tick_i) begin
            month <= next_month;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            year_count <= RST_YEAR;
        end else if (wr_year) begin
            year_count <= reg_wdata_i;
        end else if (year_step) begin
            year_count <= next_year;
        end
    end

    // century next value
    // a wrap coinciding with a write still flips the written value,
    // so a rollover is never lost to a month write in the same cycle
    always_comb begin
        if (wr_month) begin
            next_century = wdata_century ^ year_wrap;
        end else if (year_wrap) begin
            next_century = ~century_flag;
        end else begin
            next_century = century_flag;
        end
    end

    // century flag, the single stored bit of 7:5
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            century_flag <= RST_CENTURY;
        end else begin
            century_flag <= next_century;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            minute_match_disable <= RST_MATCH_DISABLE;
            minute_match_value   <= RST_MATCH_VALUE;
        end else if (wr_alarm) begin
            minute_match_disable <= wdata_disable;
            minute_match_value   <= wdata_match;
        end
    end

    // current minutes against the stored compare value
    assign minute_equal = (minutes_i == minute_match_value);

    // minute compare gated by disable
    // registered, so the match shows one cycle after the minutes change
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            minute_match_o <= 1'b0;
        end else begin
            minute_match_o <= !minute_match_disable && minute_equal;
        end
    end

    // month length decoder
    // purely combinational; its results are flopped below
    assign cal.month = month;
    assign cal.year  = year_count;
    month_length u_month_length (
        .cal (cal.limits)
    );

    // limits registered for the date counter
    // one cycle behind the registers, the date counter allows for it
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            days_in_month_o <= DAYS_31;
            leap_year_o     <= 1'b0;
        end else begin
            days_in_month_o <= cal.days_in_month;
            leap_year_o     <= cal.leap;
        end
    end

    // read mux, unused bits and unmapped offsets read zero
    always_comb begin
        unique case (reg_addr_i)
            OFS_MONTH_AND_CENTURY: begin
                next_rdata = {century_flag, 2'b00, month};
            end
            OFS_YEAR_COUNT: begin
                next_rdata = year_count;
            end
            OFS_MINUTE_MATCH_VALUE: begin
                next_rdata = {minute_match_disable, minute_match_value};
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    // read data held between reads, so a slow host may pick it up late
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
        end
    end
endmodule : month_year_minute_alarm_regs
`default_nettype wire

// ===== design/cal_regs_pkg.sv
// shared constants for the month, year and minute alarm registers
package cal_regs_pkg;
    // register offsets on the shared register port
    localparam logic [7:0] OFS_MONTH_AND_CENTURY  = 8'h07;
    localparam logic [7:0] OFS_YEAR_COUNT         = 8'h08;
    localparam logic [7:0] OFS_MINUTE_MATCH_VALUE = 8'h09;

    // field positions
    localparam int CENTURY_BIT       = 7;
    localparam int MONTH_MSB         = 4;
    localparam int MATCH_DISABLE_BIT = 7;
    localparam int MATCH_VALUE_MSB   = 6;

    // values after reset
    localparam logic [4:0] RST_MONTH         = 5'h01;
    localparam logic [7:0] RST_YEAR          = 8'h00;
    localparam logic       RST_CENTURY       = 1'b0;
    localparam logic       RST_MATCH_DISABLE = 1'b1;
    localparam logic [6:0] RST_MATCH_VALUE   = 7'h00;

    // calendar constants, all in bcd
    localparam logic [4:0] MONTH_FIRST = 5'h01;
    localparam logic [4:0] MONTH_LAST  = 5'h12;
    localparam logic [4:0] MONTH_FEB   = 5'h02;
    localparam logic [4:0] MONTH_APR   = 5'h04;
    localparam logic [4:0] MONTH_JUN   = 5'h06;
    localparam logic [4:0] MONTH_SEP   = 5'h09;
    localparam logic [4:0] MONTH_NOV   = 5'h11;
    localparam logic [7:0] YEAR_LAST   = 8'h99;
    localparam logic [5:0] DAYS_28     = 6'h28;
    localparam logic [5:0] DAYS_29     = 6'h29;
    localparam logic [5:0] DAYS_30     = 6'h30;
    localparam logic [5:0] DAYS_31     = 6'h31;
endpackage : cal_regs_pkg

// ===== design/cal_info_if.sv
// carrier between the register file and the month length decoder
`timescale 1ns/1ps
`default_nettype none
interface cal_info_if;
    logic [4:0] month;
    logic [7:0] year;
    logic       leap;
    logic [5:0] days_in_month;

    modport regs (output month, output year, input leap, input days_in_month);
    modport limits (input month, input year, output leap, output days_in_month);
endinterface : cal_info_if
`default_nettype wire

// ===== design/month_length.sv
// month length and leap year decoder for years 2000 to 2099
`timescale 1ns/1ps
`default_nettype none
module month_length
    import cal_regs_pkg::*;
(
    // calendar state in, limits out
    cal_info_if.limits cal
);
    logic       tens_even;
    logic [3:0] units;

    assign tens_even = ~cal.year[4];
    assign units     = cal.year[3:0];

    // leap year test
    // every multiple of four is leap, 2000 included, so no century test
    always_comb begin
        if (tens_even) begin
            cal.leap = (units == 4'h0) || (units == 4'h4) || (units == 4'h8);
        end else begin
            cal.leap = (units == 4'h2) || (units == 4'h6);
        end
    end

    always_comb begin
        unique case (cal.month)
            MONTH_FEB: cal.days_in_month = cal.leap ? DAYS_29 : DAYS_28;
            MONTH_APR,
            MONTH_JUN,
            MONTH_SEP,
            MONTH_NOV: cal.days_in_month = DAYS_30;
            default:   cal.days_in_month = DAYS_31;
        endcase
    end
endmodule : month_length
`default_nettype wire

// ===== testbench/cal_regs_chk.sv
// port assertions for the month, year and minute alarm registers
`timescale 1ns/1ps
`default_nettype none
module cal_regs_chk (
    // watched ports
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       month_tick_i,
    input wire logic [5:0] days_in_month_o,
    input wire logic       leap_year_o,
    input wire logic [6:0] minutes_i,
    input wire logic       minute_match_o
);
    logic exp_leap;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // bcd multiple of four: odd tens need units 2 or 6
    always_ff @(posedge clk_i) begin
        exp_leap <= reg_wdata_i[1:0] == {reg_wdata_i[4], 1'b0};
    end
    a_month_readback: assert property (
        reg_wr_i && reg_addr_i == 8'h07 && !month_tick_i ##1
        !reg_wr_i && !month_tick_i ##1
        reg_rd_i && reg_addr_i == 8'h07 |=>
        reg_rdata_o == ($past(reg_wdata_i, 3) & 8'h9F))
        else $error("month readback");
    a_year_readback: assert property (
        reg_wr_i && reg_addr_i == 8'h08 ##1 !reg_wr_i && !month_tick_i
        ##1 reg_rd_i && reg_addr_i == 8'h08 |=>
        reg_rdata_o == $past(reg_wdata_i, 3))
        else $error("year readback");
    a_leap_year: assert property (
        reg_wr_i && reg_addr_i == 8'h08 |=> ##1 leap_year_o ==
        $past(exp_leap)) else $error("leap flag");
    a_feb_days: assert property (
        days_in_month_o inside {6'h28, 6'h29} |->
        leap_year_o == days_in_month_o[0]) else $error("feb days");
    a_alarm_reset: assert property (
        !$past(rst_n_i, 2) && !$past(reg_wr_i) && reg_rd_i &&
        reg_addr_i == 8'h09 |=> reg_rdata_o == 8'h80)
        else $error("alarm reset");
    a_match_off: assert property (
        reg_wr_i && reg_addr_i == 8'h09 && reg_wdata_i[7] |=> ##1
        !minute_match_o) else $error("match not off");
    a_match_on: assert property (
        reg_wr_i && reg_addr_i == 8'h09 && !reg_wdata_i[7] ##1
        {1'b0, minutes_i} == ($past(reg_wdata_i) & 8'h7F) |=>
        minute_match_o)
        else $error("match missing");
    // main scenarios reached
    c_match: cover property (minute_match_o);
    c_feb_leap: cover property (days_in_month_o == 6'h29);
    c_tick: cover property (month_tick_i);
endmodule : cal_regs_chk
bind month_year_minute_alarm_regs cal_regs_chk i_chk (.*);
`default_nettype wire

// ===== testbench/reg_host.sv
// host model issuing single byte register accesses
`timescale 1ns/1ps
`default_nettype none
module reg_host (
    // clock and read data
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    // register port
    output logic      [7:0] addr_o,
    output logic            wr_o,
    output logic            rd_o,
    output logic      [7:0] wdata_o
);
    initial begin
        {addr_o, wr_o, rd_o, wdata_o} = '0;
    end
    // released lines are scrambled so stale values never help
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        {addr_o, wdata_o, wr_o} <= {a, d, 1'b1};
        @(posedge clk_i);
        {addr_o, wdata_o, wr_o} <= {~a, ~d, 1'b0};
    endtask : wr
    // data is taken mid-cycle, after the answering edge settles
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge clk_i);
        {addr_o, rd_o} <= {a, 1'b1};
        @(posedge clk_i);
        {addr_o, rd_o} <= {~a, 1'b0};
        @(negedge clk_i);
        q = rdata_i;
    endtask : rd
endmodule : reg_host
`default_nettype wire

// ===== testbench/test_month_year_minute_alarm_regs.sv
// self-checking bench for the month, year and minute alarm registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
    miscompares++; $display("Error %0t: got %h", $time, g); end end
module test_month_year_minute_alarm_regs;
    typedef struct packed {logic [7:0] a, w, e;} row_t;
    localparam row_t ROWS [7] = '{'{8'h07, 8'hE9, 8'h89},
        '{8'h07, 8'h12, 8'h12}, '{8'h08, 8'h99, 8'h99},
        '{8'h08, 8'h00, 8'h00}, '{8'h09, 8'h59, 8'h59},
        '{8'h09, 8'h00, 8'h00}, '{8'h0A, 8'h55, 8'h00}};
    logic       clk_i = 1'b0, rst_n_i = 1'b0, month_tick_i = 1'b0;
    logic [6:0] minutes_i = 7'h00;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, q;
    logic       reg_wr_i, reg_rd_i, leap_year_o, minute_match_o;
    logic [5:0] days_in_month_o;
    int         miscompares = 0, check_count = 0;
    always #2.5 clk_i = ~clk_i;
    month_year_minute_alarm_regs i_dut (.*);
    reg_host i_host (.clk_i(clk_i), .rdata_i(reg_rdata_o),
        .addr_o(reg_addr_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i),
        .wdata_o(reg_wdata_i));
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report
    task automatic tick;
        @(posedge clk_i) month_tick_i <= 1'b1;
        @(posedge clk_i) month_tick_i <= 1'b0;
    endtask : tick
    // watchdog: the run needs well under 1000 cycles
    initial begin
        #5000;
        miscompares++;
        final_report();
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        i_host.rd(8'h09, q); `CHK(q, 8'h80)
        i_host.rd(8'h07, q); `CHK(q, 8'h01)
        $display("reset test done");
        foreach (ROWS[i]) begin
            i_host.wr(ROWS[i].a, ROWS[i].w);
            i_host.rd(ROWS[i].a, q); `CHK(q, ROWS[i].e)
        end
        $display("table test done");
        // bcd carry from september and year wrap from december
        i_host.wr(8'h07, 8'h09);
        tick();
        i_host.rd(8'h07, q); `CHK(q, 8'h10)
        i_host.wr(8'h07, 8'h12);
        i_host.wr(8'h08, 8'h99);
        tick();
        i_host.rd(8'h07, q); `CHK(q, 8'h81)
        i_host.rd(8'h08, q); `CHK(q, 8'h00)
        `CHK(leap_year_o, 1'b1)
        $display("wrap test done");
        // limits trail the registers by one edge, so wait two negedges
        i_host.wr(8'h07, 8'h02);
        repeat (2) @(negedge clk_i);
        `CHK(days_in_month_o, 6'h29)
        i_host.wr(8'h08, 8'h01);
        repeat (2) @(negedge clk_i);
        `CHK(days_in_month_o, 6'h28)
        i_host.wr(8'h08, 8'h96);
        repeat (2) @(negedge clk_i);
        `CHK(days_in_month_o, 6'h29)
        i_host.wr(8'h07, 8'h11);
        repeat (2) @(negedge clk_i);
        `CHK(days_in_month_o, 6'h30)
        $display("leap test done");
        i_host.wr(8'h09, 8'h30);
        @(posedge clk_i) minutes_i <= 7'h30;
        repeat (2) @(negedge clk_i);
        `CHK(minute_match_o, 1'b1)
        i_host.wr(8'h09, 8'hB0);
        repeat (2) @(negedge clk_i);
        `CHK(minute_match_o, 1'b0)
        $display("match test done");
        // mid-run reset puts every register back to its default
        @(posedge clk_i) rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        i_host.rd(8'h09, q); `CHK(q, 8'h80)
        i_host.rd(8'h07, q); `CHK(q, 8'h01)
        i_host.rd(8'h08, q); `CHK(q, 8'h00)
        $display("mid-run reset test done");
        final_report();
    end
endmodule : test_month_year_minute_alarm_regs
`default_nettype wire
